/* core/ascs_action_sets.sv */
// Four synchronous action sets of one axis: trigger select, action issue, chaining
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// (RL1) Four sets, written by commands 26h-29h
// (RL2) Trigger select in word bits 3:0
// (RL3) Code 0 none, 1 compare, 2 timer
// (RL4) Codes 3-6 drive start, constant region, end
// (RL5) Codes 7-9 split start, end, each pulse
// (RL6) Codes A-F pin edges, C-F companion level qualified
// (RL7) Action select in word bits 8:4
// (RL8) Codes 01-04 load compare register into parameters
// (RL9) Codes 05-08 save values into compare register
// (RL10) Code 09 pulses the set's own pin
// (RL11) Codes 0A-0E start position or continuous drives
// (RL12) Code 0F relative drive by compare value
// (RL13) Codes 11-18 stops, speed, timer, split control
// (RL14) Bits 11:9 chain to other sets, rotating
// (RL15) Bits 14:12 chain set 0 of other axes
// (RL16) Bit 15 clear: disable after first firing
// (RL17) All word bits zero after reset
// (RL18) Action issued one cycle after trigger, enabled only
// (RL19) Unassigned action codes do nothing; here they still chain and still disable a one-shot set
module ascs_action_sets
  import ascs_pkg::*;
#(
  parameter int PINS = 8
)
(
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire logic            cmdWrite,
  input  wire logic [7:0]      cmdCode,
  input  wire logic [15:0]     paramWriteLow,
  input  wire logic [3:0]      enableWrite,
  input  wire ascs_event_type  events,
  input  wire logic [PINS-1:0] gpPinIn,
  input  wire logic            axisChainIn,
  output ascs_action_type      action,
  output logic [3:0]           gpPinOut,
  output logic [3:0]           gpPinOe,
  output logic [2:0]           chainOtherAxes,
  output logic [3:0]           setEnabled
);

  typedef struct packed {
    logic [3:0][15:0] mode;
    logic [3:0]       enabled;
    ascs_action_type  act;
    logic [3:0]       gpPulse;
    logic [2:0]       axisOut;
  } ascs_state_type;

  ascs_state_type st;
  ascs_state_type next_st;

  logic [PINS-1:0] pinLevel;
  logic [PINS-1:0] pinRise;
  logic [PINS-1:0] pinFall;

  // Filtered general-purpose pins, own and companion
  ascs_pin_sync #(
    .WIDTH (PINS)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pinIn   (gpPinIn),
    .level   (pinLevel),
    .rise    (pinRise),
    .fall    (pinFall)
  );

  // Trigger decode for one set
  function automatic logic trigger_hit(input logic [3:0] sel, input int m);
    logic own;
    logic comp;
    own  = 1'b0;
    comp = pinLevel[(m + 4) % PINS];
    case (sel)
      TRG_NONE:      own = 1'b0;                         // [RL3]
      TRG_COMPARE:   own = events.compareTrue[m];        // [RL3]
      TRG_TIMER:     own = events.timerUp;               // [RL3]
      TRG_DRV_START: own = events.driveStart;            // [RL4]
      TRG_CONST_IN:  own = events.constStart;            // [RL4]
      TRG_CONST_OUT: own = events.constEnd;              // [RL4]
      TRG_DRV_END:   own = events.driveEnd;              // [RL4]
      TRG_SPL_START: own = events.splitStart;            // [RL5]
      TRG_SPL_END:   own = events.splitEnd;              // [RL5]
      TRG_SPL_OUT:   own = events.splitOut;              // [RL5]
      TRG_PIN_RISE:  own = pinRise[m];                   // [RL6]
      TRG_PIN_FALL:  own = pinFall[m];                   // [RL6]
      TRG_LO_RISE:   own = ~comp & pinRise[m];           // [RL6]
      TRG_HI_RISE:   own = comp & pinRise[m];            // [RL6]
      TRG_LO_FALL:   own = ~comp & pinFall[m];           // [RL6]
      TRG_HI_FALL:   own = comp & pinFall[m];            // [RL6]
      default:       own = 1'b0;
    endcase
    return own;
  endfunction

  // Action codes that carry a meaning
  function automatic logic action_valid(input logic [4:0] code);
    logic known;
    known = code != ACT_NONE;
    known = known && code != ACT_RESERVED;
    known = known && code <= ACT_LAST;                    // [RL19]
    return known;
  endfunction

  // Set index addressed by a command code, meaningful for 26h-29h only
  function automatic logic [1:0] word_index(input logic [7:0] code);
    logic [7:0] offset;
    offset = code - CMD_SET0;
    return offset[1:0];
  endfunction

  logic            wordWrite;
  logic [1:0]      wordSel;

  // Command decode: only the four set codes touch a word
  assign wordWrite = cmdWrite && cmdCode >= CMD_SET0 && cmdCode <= CMD_SET3; // [RL1]
  assign wordSel   = word_index(cmdCode);

  // Fields of each set's parameter word
  logic [3:0][3:0] trigSel;
  logic [3:0][4:0] actSel;
  logic [3:0][2:0] chainSets;
  logic [3:0][2:0] chainAxes;
  logic [3:0]      repeatFire;

  // Split every word once so the decode below reads named fields
  always_comb
  begin
    for (int m = 0; m < 4; m++)
    begin
      trigSel[m]    = st.mode[m][TRIG_LSB +: 4];          // [RL2]
      actSel[m]     = st.mode[m][ACT_LSB +: 5];           // [RL7]
      chainSets[m]  = st.mode[m][SETS_LSB +: 3];          // [RL14]
      chainAxes[m]  = st.mode[m][AXES_LSB +: 3];          // [RL15]
      repeatFire[m] = st.mode[m][REPEAT_BIT];             // [RL16]
    end
  end

  logic [3:0] hit;
  logic [3:0] chained;
  logic [3:0] fire;

  // Own triggers, set chaining and axis chaining
  always_comb
  begin
    chained = 4'h0;
    for (int m = 0; m < 4; m++)
      hit[m] = trigger_hit(trigSel[m], m);                // [RL2]
    // Chaining is one level deep: only own hits spread, so sets
    // pointing at each other cannot form a combinational loop
    for (int k = 0; k < 4; k++)
    begin
      for (int j = 1; j < 4; j++)
      begin
        if (hit[k] && st.enabled[k] && chainSets[k][j - 1])
          chained[(k + j) % 4] = 1'b1;                    // [RL14]
      end
    end
    chained[0] = chained[0] | axisChainIn;
    fire       = st.enabled & (hit | chained);          // [RL18]
  end

  // Next state: parameter writes, enables, issued actions
  always_comb
  begin
    next_st         = st;
    next_st.act     = '0;
    next_st.gpPulse = 4'h0;
    next_st.axisOut = 3'h0;
    for (int m = 0; m < 4; m++)
    begin
      if (fire[m])
      begin
        // Actions 01-0F and 11-18 go to the axis logic as a pulse with its code
        next_st.act.code[m] = actSel[m];                  // [RL7]
        next_st.act.fire[m] = action_valid(actSel[m]);    // [RL8] [RL9] [RL11] [RL12] [RL13]
        next_st.gpPulse[m]  = actSel[m] == ACT_GP_PULSE;  // [RL10]
        next_st.axisOut     = next_st.axisOut | chainAxes[m]; // [RL15]
        // A nop firing still counts as the one allowed firing
        if (!repeatFire[m])
          next_st.enabled[m] = 1'b0;                      // [RL16]
      end
      // Re-enable wins over a same-cycle one-shot disable
      if (enableWrite[m])
        next_st.enabled[m] = 1'b1;
    end
    // Parameter word write by command code
    // A write does not touch the enable: the host re-enables separately
    if (wordWrite)
      next_st.mode[wordSel] = paramWriteLow;              // [RL1]
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      next_st_reset();
    end
    else
      st <= next_st;
  end

  // Reset values of every field
  task automatic next_st_reset();
    st.mode    <= {4{MODE_RESET}};                        // [RL17]
    st.enabled <= 4'h0;
    st.act     <= '0;
    st.gpPulse <= 4'h0;
    st.axisOut <= 3'h0;
  endtask

  // Outputs straight from the state register, gpPinOut tied low
  assign action         = st.act;
  assign gpPinOut       = 4'h0;                           // Pin pulled low
  assign gpPinOe        = st.gpPulse;                     // [RL10]
  assign chainOtherAxes = st.axisOut;
  assign setEnabled     = st.enabled;

endmodule
`default_nettype wire

/* core/ascs_pin_sync.sv */
// Pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ns
`default_nettype none
module ascs_pin_sync
  import ascs_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;
  } ascs_sync_type;

  ascs_sync_type st;
  ascs_sync_type next_st;

  // Accept a new level only once stages two and three agree
  always_comb
  begin
    next_st    = st;
    next_st.s1 = pinIn;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      next_st.rise[i] = 1'b0;
      next_st.fall[i] = 1'b0;
      if (st.s2[i] == st.s3[i] && st.s3[i] != st.level[i])
      begin
        next_st.level[i] = st.s3[i];
        next_st.rise[i]  = st.s3[i];
        next_st.fall[i]  = ~st.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign level = st.level;
  assign rise  = st.rise;
  assign fall  = st.fall;

endmodule
`default_nettype wire

/* core/ascs_pkg.sv */
// Package: constants and carrier types for the per-axis synchronous action sets
package ascs_pkg;

  // Host command codes for the four set parameter words
  localparam logic [7:0] CMD_SET0 = 8'h26;
  localparam logic [7:0] CMD_SET3 = 8'h29;

  // Field positions inside a set's parameter word
  localparam int TRIG_LSB   = 0;
  localparam int ACT_LSB    = 4;
  localparam int SETS_LSB   = 9;
  localparam int AXES_LSB   = 12;
  localparam int REPEAT_BIT = 15;

  // Parameter word value after reset
  localparam logic [15:0] MODE_RESET = 16'h0000;

  // Trigger select codes
  localparam logic [3:0] TRG_NONE      = 4'h0;
  localparam logic [3:0] TRG_COMPARE   = 4'h1;
  localparam logic [3:0] TRG_TIMER     = 4'h2;
  localparam logic [3:0] TRG_DRV_START = 4'h3;
  localparam logic [3:0] TRG_CONST_IN  = 4'h4;
  localparam logic [3:0] TRG_CONST_OUT = 4'h5;
  localparam logic [3:0] TRG_DRV_END   = 4'h6;
  localparam logic [3:0] TRG_SPL_START = 4'h7;
  localparam logic [3:0] TRG_SPL_END   = 4'h8;
  localparam logic [3:0] TRG_SPL_OUT   = 4'h9;
  localparam logic [3:0] TRG_PIN_RISE  = 4'ha;
  localparam logic [3:0] TRG_PIN_FALL  = 4'hb;
  localparam logic [3:0] TRG_LO_RISE   = 4'hc;
  localparam logic [3:0] TRG_HI_RISE   = 4'hd;
  localparam logic [3:0] TRG_LO_FALL   = 4'he;
  localparam logic [3:0] TRG_HI_FALL   = 4'hf;

  // Action select codes: none, pin pulse, reserved, last with a meaning
  localparam logic [4:0] ACT_NONE      = 5'h00;
  localparam logic [4:0] ACT_GP_PULSE  = 5'h09;
  localparam logic [4:0] ACT_RESERVED  = 5'h10;
  localparam logic [4:0] ACT_LAST      = 5'h18;

  // Compare, drive, timer and split events of the axis, one-cycle pulses
  typedef struct packed {
    logic [3:0] compareTrue;
    logic       timerUp;
    logic       driveStart;
    logic       constStart;
    logic       constEnd;
    logic       driveEnd;
    logic       splitStart;
    logic       splitEnd;
    logic       splitOut;
  } ascs_event_type;

  // Actions handed to the axis logic, one-cycle pulses
  typedef struct packed {
    logic [3:0]      fire;
    logic [3:0][4:0] code;
  } ascs_action_type;

endpackage

/* verif/ascs_action_sets_bench.sv */
// Testbench: action sets against expected values worked out in the sequence
`timescale 1ns/1ns
`default_nettype none
module ascs_action_sets_bench
  import ascs_pkg::*;
;
  logic            sys_clk = 1'b0;
  logic            rst = 1'b1;
  logic            cmdWrite;
  logic [7:0]      cmdCode;
  logic [15:0]     paramWriteLow;
  logic [3:0]      enableWrite;
  ascs_event_type  events = '0;
  logic [7:0]      gpPinIn = 8'h00;
  logic            axisChainIn = 1'b0;
  ascs_action_type action;
  logic [3:0]      gpPinOut;
  logic [3:0]      gpPinOe;
  logic [2:0]      chainOtherAxes;
  logic [3:0]      setEnabled;
  logic [31:0]     lfsrState = 32'he3ec3c55;
  int              error_cnt = 0;
  int              cmp_count = 0;
  int              wrd [4];
  int              act;
  int              m;
  int              fire;
  ascs_host_model host (.sys_clk(sys_clk), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
    .paramWriteLow(paramWriteLow), .enableWrite(enableWrite));
  ascs_action_sets ascs_action_sets_inst (.sys_clk(sys_clk), .rst(rst), .cmdWrite(cmdWrite),
    .cmdCode(cmdCode), .paramWriteLow(paramWriteLow), .enableWrite(enableWrite),
    .events(events), .gpPinIn(gpPinIn), .axisChainIn(axisChainIn), .action(action),
    .gpPinOut(gpPinOut), .gpPinOe(gpPinOe), .chainOtherAxes(chainOtherAxes),
    .setEnabled(setEnabled));
  always #20 sys_clk = ~sys_clk;
  function automatic int lfsr();
    lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
    return int'(lfsrState[15:0]);
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #40000;
    error_cnt++;
    conclude();
  end
  // Main sequence
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk(16'(setEnabled), 16'h0);
    for (int t = 0; t < 10; t++)
    begin
      m = t % 4;
      act = lfsr() % 25;
      wrd[m] = (lfsr() & 32'h8000) | (act << 4) | t;
      host.wr(CMD_SET0 + 8'(m), 16'(wrd[m]));
      host.en(m);
      @(posedge sys_clk);
      events <= (t == 1) ? 12'h100 << m : 12'h1 << (9 - t);
      @(posedge sys_clk);
      events <= '0;
      #1;
      fire = (t != 0 && act != 0 && act != 16) ? 1 : 0;
      chk(16'(action.fire), 16'(fire << m));
      chk(16'(gpPinOe), 16'(act == 9 ? fire << m : 0));
      if (t != 0) chk(16'(action.code[m]), 16'(act));
      chk(16'(setEnabled[m]), 16'(t == 0 || wrd[m][15]));
    end
    $display("trigger table test done");
    host.wr(8'h27, 16'h80a0);
    host.wr(CMD_SET0, 16'h92b3);
    host.en(0);
    host.en(1);
    @(posedge sys_clk);
    events <= 12'h040;
    @(posedge sys_clk);
    events <= '0;
    axisChainIn <= 1'b1;
    #1;
    chk(16'({action.fire, chainOtherAxes}), 16'h19);
    chk(16'(action.code[1]), 16'h0a);
    @(posedge sys_clk);
    axisChainIn <= 1'b0;
    #1;
    chk(16'(action.fire[0]), 16'h1);
    $display("chain test done");
    host.wr(CMD_SET0, 16'h009d);
    host.wr(8'h25, 16'h8003);
    host.en(0);
    @(posedge sys_clk);
    gpPinIn <= 8'h10;
    repeat (4) @(posedge sys_clk);
    gpPinIn <= 8'h11;
    repeat (5) @(posedge sys_clk);
    #1;
    chk(16'({action.fire, gpPinOe, setEnabled}),
      16'({8'h11, 1'(wrd[3][15]), 1'(wrd[2][15]), 2'b10}));
    $display("pin test done");
    conclude();
  end
endmodule
`default_nettype wire

/* verif/ascs_action_sets_monitor.sv */
// Checker: port assertions of the action sets
`timescale 1ns/1ns
`default_nettype none
module ascs_action_sets_monitor
  import ascs_pkg::*;
#(parameter int PINS = 8)
(
  input wire logic            sys_clk,
  input wire logic            rst,
  input wire logic            cmdWrite,
  input wire logic [7:0]      cmdCode,
  input wire logic [15:0]     paramWriteLow,
  input wire logic [3:0]      enableWrite,
  input wire ascs_event_type  events,
  input wire logic [PINS-1:0] gpPinIn,
  input wire logic            axisChainIn,
  input wire ascs_action_type action,
  input wire logic [3:0]      gpPinOut,
  input wire logic [3:0]      gpPinOe,
  input wire logic [2:0]      chainOtherAxes,
  input wire logic [3:0]      setEnabled
);
  logic [15:0] w0;
  logic [4:0]  a0;
  // Shadow of the set 0 word
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      w0 <= MODE_RESET;
    else if (cmdWrite && cmdCode == CMD_SET0)
      w0 <= paramWriteLow;
  end
  assign a0 = w0[8:4];
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);
  rst_clear_a: assert property (disable iff (1'b0)
    rst |=> action.fire == 4'h0 && setEnabled == 4'h0) else $error("reset left state");
  fire_on_a: assert property (action.fire[0] |-> $past(setEnabled[0]))
    else $error("disabled set fired");
  pulse_oe_a: assert property (gpPinOe[0] |-> action.fire[0] && action.code[0] == ACT_GP_PULSE)
    else $error("stray pin pulse");
  pin_low_a: assert property (gpPinOut == 4'h0) else $error("pin level not low");
  once_off_a: assert property (action.fire[0] && !$past(w0[REPEAT_BIT])
    && !$past(enableWrite[0]) |-> !setEnabled[0]) else $error("one-shot stayed on");
  repeat_on_a: assert property (action.fire[0] && $past(w0[REPEAT_BIT]) |-> setEnabled[0])
    else $error("repeat set turned off");
  nop_code_a: assert property (action.fire[0] |-> action.code[0] != ACT_NONE
    && action.code[0] != ACT_RESERVED && action.code[0] <= ACT_LAST) else $error("nop issued");
  start_fire_a: assert property (events.driveStart && setEnabled[0] && w0[3:0] == TRG_DRV_START
    && a0 != ACT_NONE && a0 != ACT_RESERVED && a0 <= ACT_LAST |=> action.fire[0])
    else $error("drive start missed");
  cover property (gpPinOe[0]);
  cover property (chainOtherAxes[0]);
  cover property (action.fire[1] && action.fire[0]);
endmodule
bind ascs_action_sets ascs_action_sets_monitor #(.PINS(PINS)) mon_inst (.*);
`default_nettype wire

/* verif/ascs_host_model.sv */
// Host model: parameter words and enables
`timescale 1ns/1ns
`default_nettype none
module ascs_host_model
(
  input  wire logic   sys_clk,
  output logic        cmdWrite,
  output logic [7:0]  cmdCode,
  output logic [15:0] paramWriteLow,
  output logic [3:0]  enableWrite
);
  // Idle levels from time zero
  initial
  begin
    cmdWrite = 1'b0;
    cmdCode = 8'h00;
    paramWriteLow = 16'h0000;
    enableWrite = 4'h0;
  end
  // One whole 16-bit word per command
  task automatic wr(input logic [7:0] code, input logic [15:0] word);
    @(posedge sys_clk);
    cmdWrite <= 1'b1;
    cmdCode <= code;
    paramWriteLow <= word;
    @(posedge sys_clk);
    cmdWrite <= 1'b0;
    paramWriteLow <= ~word;
  endtask
  // Re-enable one set
  task automatic en(input int m);
    @(posedge sys_clk);
    enableWrite <= 4'(1 << m);
    @(posedge sys_clk);
    enableWrite <= 4'h0;
  endtask
endmodule
`default_nettype wire
